// >>> cap_regs_pkg.sv
// Operation
// - Control bit 31 (MSI-X enable) resets to 0, is read-write, and permits MSI-X messages while set.
// - Control bit 30 (function mask) resets to 0, is read-write, and masks every MSI-X interrupt while set.
// - Bits 26:16 of the control register report table entries minus one, at most 0x7FF, read-only.
// - Bits 15:8 of the MSI-X header read 0x80 as the next-capability pointer.
// - Bits 7:0 of the MSI-X header read the capability identifier 0x11.
// - Bits 2:0 at 0x06C read the configured BAR code that holds the MSI-X table.
// - Bits 31:3 at 0x06C read the configured quad-word-aligned table offset.
// - Bits 2:0 at 0x070 read the configured BAR code that holds the pending bit array.
// - Bits 31:3 at 0x070 read the configured quad-word-aligned pending array offset.
// - Power capabilities bits 18:16 read version 0x3 and bits 31:19 read zero.
// - Power capabilities bits 15:8 read the next pointer 0x80.
// - Power capabilities bits 7:0 read the identifier 0x01.
// - Control/status bit 3 reads the configured no-soft-reset flag.
// - Control/status bits 1:0 hold the power state, reset to D0, writable with D0 or D3hot only.
package cap_regs_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] OFS_MSIX_CTRL  = 8'h68;
    localparam logic [7:0] OFS_MSIX_TABLE = 8'h6C;
    localparam logic [7:0] OFS_MSIX_PBA   = 8'h70;
    localparam logic [7:0] OFS_PM_CAP     = 8'h78;
    localparam logic [7:0] OFS_PM_CSR     = 8'h7C;

    // ----------------------------------------
    // Fields and fixed values
    // ----------------------------------------
    localparam int          BIT_MSIX_EN    = 31;
    localparam int          BIT_MSIX_MASK  = 30;
    localparam int          BIT_NO_SOFT_RST = 3;
    localparam logic [7:0]  MSIX_CAP_ID    = 8'h11;
    localparam logic [7:0]  MSIX_NEXT_PTR  = 8'h80;
    localparam logic [7:0]  PM_CAP_ID      = 8'h01;
    localparam logic [7:0]  PM_NEXT_PTR    = 8'h80;
    localparam logic [2:0]  PM_VERSION     = 3'h3;
    localparam logic [10:0] TBL_SIZE_MAX   = 11'h7FF;
    localparam logic [1:0]  PSTATE_D0      = 2'h0;
    localparam logic [1:0]  PSTATE_D3HOT   = 2'h3;
    localparam logic [2:0]  BAR_CODE_MAX   = 3'h5;

    // Configured location of a table in a BAR
    typedef struct packed {
        logic [28:0] qw_offset;
        logic [2:0]  bar_code;
    } bar_loc_s;

    // Software-visible control state
    typedef struct packed {
        logic       msix_en;
        logic       msix_mask;
        logic [1:0] pstate;
    } cap_ctrl_s;

endpackage

// >>> pstate_filter.sv
`timescale 1ns/10ps
module pstate_filter
    import cap_regs_pkg::*;
(
    // Request
    input  wire logic [1:0] wr_value,
    input  wire logic [1:0] cur_value,
    // Result
    output logic [1:0]      nxt_value,
    output logic            accepted
);

    // Only D0 and D3hot are legal; anything else keeps the old state
    assign accepted  = (wr_value == PSTATE_D0) || (wr_value == PSTATE_D3HOT);
    assign nxt_value = accepted ? wr_value : cur_value;

endmodule

// >>> msix_pm_capability_regs.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module msix_pm_capability_regs
    import cap_regs_pkg::*;
#(
    parameter logic [10:0] TABLE_SIZE_M1   = 11'h0,
    parameter logic [2:0]  TABLE_BAR       = 3'h0,
    parameter logic [28:0] TABLE_QW_OFFSET = 29'h0,
    parameter logic [2:0]  PBA_BAR         = 3'h1,
    parameter logic [28:0] PBA_QW_OFFSET   = 29'h0,
    parameter logic        NO_SOFT_RESET   = 1'b0
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic [31:0]      rdata,
    // Block state
    output cap_ctrl_s        ctrl,
    output logic             msix_gen_allowed,
    output bar_loc_s         table_loc,
    output bar_loc_s         pba_loc
);

    // ----------------------------------------
    // Control state
    // ----------------------------------------
    logic       msix_en_ff;
    logic       msix_mask_ff;
    logic [1:0] pstate_ff;
    logic [1:0] nxt_pstate;
    logic       pstate_ok;
    logic [31:0] rdata_ff;

    pstate_filter u_pstate (
        .wr_value  (wdata[1:0]),
        .cur_value (pstate_ff),
        .nxt_value (nxt_pstate),
        .accepted  (pstate_ok)
    );

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            msix_en_ff   <= 1'b0;
            msix_mask_ff <= 1'b0;
        end else if (wr_stb && addr == OFS_MSIX_CTRL) begin
            msix_en_ff   <= wdata[BIT_MSIX_EN];
            msix_mask_ff <= wdata[BIT_MSIX_MASK];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pstate_ff <= PSTATE_D0;
        end else if (wr_stb && addr == OFS_PM_CSR) begin
            pstate_ff <= nxt_pstate;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Size field is clamped so a bad parameter cannot exceed the field
    logic [10:0] tbl_size;
    assign tbl_size = (TABLE_SIZE_M1 > TBL_SIZE_MAX) ? TBL_SIZE_MAX : TABLE_SIZE_M1;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        case (addr)
            OFS_MSIX_CTRL: begin
                rd_mux[BIT_MSIX_EN]   = msix_en_ff;
                rd_mux[BIT_MSIX_MASK] = msix_mask_ff;
                rd_mux[26:16]         = tbl_size;
                rd_mux[15:8]          = MSIX_NEXT_PTR;
                rd_mux[7:0]           = MSIX_CAP_ID;
            end
            OFS_MSIX_TABLE: begin
                rd_mux = {TABLE_QW_OFFSET, TABLE_BAR};
            end
            OFS_MSIX_PBA: begin
                rd_mux = {PBA_QW_OFFSET, PBA_BAR};
            end
            OFS_PM_CAP: begin
                rd_mux[18:16] = PM_VERSION;
                rd_mux[15:8]  = PM_NEXT_PTR;
                rd_mux[7:0]   = PM_CAP_ID;
            end
            OFS_PM_CSR: begin
                rd_mux[BIT_NO_SOFT_RST] = NO_SOFT_RESET;
                rd_mux[1:0]             = pstate_ff;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    // Unmapped reads and idle cycles return zero
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_ff <= 32'h0;
        end else begin
            rdata_ff <= rd_stb ? rd_mux : 32'h0;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata            = rdata_ff;
    assign ctrl             = '{msix_en: msix_en_ff, msix_mask: msix_mask_ff, pstate: pstate_ff};
    // Power state is not looked at; the function mask blocks all vectors
    assign msix_gen_allowed = msix_en_ff && !msix_mask_ff;
    assign table_loc        = '{qw_offset: TABLE_QW_OFFSET, bar_code: TABLE_BAR};
    assign pba_loc          = '{qw_offset: PBA_QW_OFFSET, bar_code: PBA_BAR};

    // ----------------------------------------
    // Checks: reset
    // ----------------------------------------
    // No reset guard here, since reset is what they watch
    AST_RST_EN: assert property (@(posedge mclk)
        sys_rst
        |=> !msix_en_ff)
        else $error("enable not cleared by reset");

    AST_RST_MASK: assert property (@(posedge mclk)
        sys_rst
        |=> !msix_mask_ff)
        else $error("mask not cleared by reset");

    AST_RST_PSTATE: assert property (@(posedge mclk)
        sys_rst
        |=> pstate_ff == PSTATE_D0)
        else $error("power state not cleared by reset");

    AST_RST_RDATA: assert property (@(posedge mclk)
        sys_rst
        |=> rdata == 32'h0)
        else $error("read data not cleared by reset");

    // ----------------------------------------
    // Checks: enable and mask
    // ----------------------------------------
    AST_EN_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && addr == OFS_MSIX_CTRL
        |=> msix_en_ff == $past(wdata[BIT_MSIX_EN]))
        else $error("enable not written");

    AST_MASK_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && addr == OFS_MSIX_CTRL
        |=> msix_mask_ff == $past(wdata[BIT_MSIX_MASK]))
        else $error("mask not written");

    AST_EN_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        !(wr_stb && addr == OFS_MSIX_CTRL)
        |=> $stable(msix_en_ff))
        else $error("enable changed without a write");

    AST_MASK_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        !(wr_stb && addr == OFS_MSIX_CTRL)
        |=> $stable(msix_mask_ff))
        else $error("mask changed without a write");

    AST_MASK_GATES: assert property (@(posedge mclk) disable iff (sys_rst)
        msix_mask_ff
        |-> !msix_gen_allowed)
        else $error("mask did not gate");

    AST_EN_GATES: assert property (@(posedge mclk) disable iff (sys_rst)
        !msix_en_ff
        |-> !msix_gen_allowed)
        else $error("generation allowed while disabled");

    AST_EN_GRANT: assert property (@(posedge mclk) disable iff (sys_rst)
        msix_en_ff && !msix_mask_ff
        |-> msix_gen_allowed)
        else $error("generation refused while enabled");

    // ----------------------------------------
    // Checks: capability header reads
    // ----------------------------------------
    AST_HDR_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_CTRL
        |=> rdata[15:8] == MSIX_NEXT_PTR)
        else $error("msix next pointer wrong");

    AST_ID_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_CTRL
        |=> rdata[7:0] == MSIX_CAP_ID)
        else $error("msix identifier wrong");

    AST_SIZE_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_CTRL
        |=> rdata[26:16] == TABLE_SIZE_M1)
        else $error("table size wrong");

    AST_EN_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_CTRL
        |=> rdata[BIT_MSIX_EN] == $past(msix_en_ff))
        else $error("enable read back wrong");

    AST_MASK_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_CTRL
        |=> rdata[BIT_MSIX_MASK] == $past(msix_mask_ff))
        else $error("mask read back wrong");

    AST_CTRL_RSVD: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_CTRL
        |=> rdata[29:27] == 3'h0)
        else $error("control reserved bits not zero");

    // ----------------------------------------
    // Checks: table and pending array locations
    // ----------------------------------------
    // Locations are fixed at build time, so software cannot move them
    AST_TBL_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_TABLE
        |=> rdata[31:3] == TABLE_QW_OFFSET)
        else $error("table offset wrong");

    AST_TBL_BAR: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_TABLE
        |=> rdata[2:0] == TABLE_BAR)
        else $error("table bar code wrong");

    AST_PBA_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_PBA
        |=> rdata[31:3] == PBA_QW_OFFSET)
        else $error("pending array offset wrong");

    AST_PBA_BAR: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_MSIX_PBA
        |=> rdata[2:0] == PBA_BAR)
        else $error("pending array bar code wrong");

    AST_TBL_OUT: assert property (@(posedge mclk) disable iff (sys_rst)
        1'b1
        |-> table_loc.bar_code == TABLE_BAR && table_loc.qw_offset == TABLE_QW_OFFSET)
        else $error("table location output wrong");

    AST_PBA_OUT: assert property (@(posedge mclk) disable iff (sys_rst)
        1'b1
        |-> pba_loc.bar_code == PBA_BAR && pba_loc.qw_offset == PBA_QW_OFFSET)
        else $error("pending array location output wrong");

    // ----------------------------------------
    // Checks: power management
    // ----------------------------------------
    // Writes of 01 or 10 leave the field alone rather than saturating
    AST_PM_CAP: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_PM_CAP
        |=> rdata[31:19] == 13'h0 && rdata[18:16] == PM_VERSION)
        else $error("power_mgmt_capabilities wrong");

    AST_PM_NEXT: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_PM_CAP
        |=> rdata[15:8] == PM_NEXT_PTR)
        else $error("pm next pointer wrong");

    AST_PM_ID: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_PM_CAP
        |=> rdata[7:0] == PM_CAP_ID)
        else $error("pm identifier wrong");

    AST_NSR_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_PM_CSR
        |=> rdata[BIT_NO_SOFT_RST] == NO_SOFT_RESET)
        else $error("no soft reset flag wrong");

    AST_PSTATE_READ: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_PM_CSR
        |=> rdata[1:0] == $past(pstate_ff))
        else $error("power state read back wrong");

    AST_PSTATE_TAKE: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && addr == OFS_PM_CSR && (wdata[1:0] == PSTATE_D0 || wdata[1:0] == PSTATE_D3HOT)
        |=> pstate_ff == $past(wdata[1:0]))
        else $error("legal power state not taken");

    AST_PSTATE_KEEP: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && addr == OFS_PM_CSR && (wdata[1:0] == 2'h1 || wdata[1:0] == 2'h2)
        |=> $stable(pstate_ff))
        else $error("illegal power state taken");

    AST_PSTATE_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
        !(wr_stb && addr == OFS_PM_CSR)
        |=> $stable(pstate_ff))
        else $error("power state changed without a write");

    AST_PSTATE_LEGAL: assert property (@(posedge mclk) disable iff (sys_rst)
        1'b1
        |-> pstate_ff == PSTATE_D0 || pstate_ff == PSTATE_D3HOT)
        else $error("power state illegal");

    AST_CTRL_CAUSE: assert property (@(posedge mclk) disable iff (sys_rst)
        $changed(ctrl)
        |-> $past(wr_stb))
        else $error("control changed without a write");

    // ----------------------------------------
    // Checks: reserved bits and idle bus
    // ----------------------------------------
    // Zero between reads keeps a stale word off the bus
    AST_CSR_RSVD: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == OFS_PM_CSR
        |=> rdata[31:4] == 28'h0 && !rdata[2])
        else $error("reserved bits not zero");

    AST_IDLE_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
        !rd_stb
        |=> rdata == 32'h0)
        else $error("read data not zero when idle");

    AST_UNMAPPED: assert property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr != OFS_MSIX_CTRL && addr != OFS_MSIX_TABLE && addr != OFS_MSIX_PBA
            && addr != OFS_PM_CAP && addr != OFS_PM_CSR |=> rdata == 32'h0)
        else $error("unmapped read not zero");

    AST_RO_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && addr != OFS_MSIX_CTRL
        |=> $stable(msix_en_ff) && $stable(msix_mask_ff))
        else $error("control changed by a foreign write");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    COV_ENABLE: cover property (@(posedge mclk) disable iff (sys_rst) $rose(msix_gen_allowed));

    COV_D3: cover property (@(posedge mclk) disable iff (sys_rst) pstate_ff == PSTATE_D3HOT);

    COV_BAD_PS: cover property (@(posedge mclk) disable iff (sys_rst)
        wr_stb && addr == OFS_PM_CSR && !pstate_ok);

    COV_MASKED: cover property (@(posedge mclk) disable iff (sys_rst) msix_en_ff && msix_mask_ff);

    COV_UNMAPPED: cover property (@(posedge mclk) disable iff (sys_rst)
        rd_stb && addr == 8'h74);

endmodule

// >>> cfg_host.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host configuration master
// ----------------------------------------
module cfg_host (
    // Clock
    input  wire logic        mclk,
    // Register port
    output logic [7:0]       addr,
    output logic [31:0]      wdata,
    output logic             wr_stb,
    output logic             rd_stb,
    input  wire logic [31:0] rdata
);
    initial begin
        addr   = 8'h00;
        wdata  = 32'h00000000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // Power state is written with D0 or D3hot only, unless a refusal is wanted
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        @(negedge mclk);
    endtask

    // Read data stand one cycle only, so take them mid-cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import cap_regs_pkg::*;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic [31:0] rv;
    cap_ctrl_s   ctrl;
    logic        msix_gen_allowed;
    bar_loc_s    table_loc;
    bar_loc_s    pba_loc;
    int          n_mismatch = 0;
    int          n_checks = 0;

    always #25 mclk = ~mclk;

    // ----------------------------------------
    // Device and host
    // ----------------------------------------
    msix_pm_capability_regs #(.TABLE_SIZE_M1(11'h7FF), .TABLE_BAR(3'h3),
        .TABLE_QW_OFFSET(29'h1234567), .PBA_QW_OFFSET(29'h0ABCDEF),
        .NO_SOFT_RESET(1'b1)) msix_pm_capability_regs_i (.mclk(mclk), .sys_rst(sys_rst),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .ctrl(ctrl), .msix_gen_allowed(msix_gen_allowed), .table_loc(table_loc),
        .pba_loc(pba_loc));
    cfg_host cfg_host_i (.mclk(mclk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata));

    // ----------------------------------------
    // Checks and verdict
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        cfg_host_i.rd(a, rv);
        chk("rdata", e, rv);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // A hang counts as a failure rather than running forever
    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        rchk(8'h68, 32'h07FF8011);
        rchk(8'h6C, 32'h091A2B3B);
        rchk(8'h70, 32'h055E6F79);
        rchk(8'h78, 32'h00038001);
        rchk(8'h7C, 32'h00000008);
        chk("table_loc", 32'h091A2B3B, table_loc);
        chk("pba_loc", 32'h055E6F79, pba_loc);
        cfg_host_i.wr(8'h68, 32'hFFFFFFFF);
        rchk(8'h68, 32'hC7FF8011);
        chk("allowed", 32'h0, {31'h0, msix_gen_allowed});
        cfg_host_i.wr(8'h68, 32'h80000000);
        chk("allowed", 32'h1, {31'h0, msix_gen_allowed});
        rchk(8'h68, 32'h87FF8011);
        cfg_host_i.wr(8'h6C, 32'hFFFFFFFF);
        rchk(8'h6C, 32'h091A2B3B);
        cfg_host_i.wr(8'h78, 32'hFFFFFFFF);
        rchk(8'h78, 32'h00038001);
        cfg_host_i.wr(8'h74, 32'hFFFFFFFF);
        rchk(8'h74, 32'h00000000);
        cfg_host_i.wr(8'h7C, 32'hFFFFFFFF);
        rchk(8'h7C, 32'h0000000B);
        cfg_host_i.wr(8'h7C, 32'h00000001);
        rchk(8'h7C, 32'h0000000B);
        cfg_host_i.wr(8'h7C, 32'h00000002);
        rchk(8'h7C, 32'h0000000B);
        cfg_host_i.wr(8'h7C, 32'h00000000);
        rchk(8'h7C, 32'h00000008);
        cfg_host_i.wr(8'h7C, 32'h00000003);
        cfg_host_i.wr(8'h68, 32'h40000000);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        chk("ctrl", 32'h0, {28'h0, ctrl});
        rchk(8'h68, 32'h07FF8011);
        finish_test();
    end
endmodule
